// File: sfmio_core.sv
// Serial flash fast/dual/quad read and page program sequencer on SPI pins
`timescale 1ns/100ps
`default_nettype none
`include "sfmio_defines.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module sfmio_core #(
    parameter int unsigned TPP_CYCLES = (`SFMIO_TPP_NS + `SFMIO_CLK_NS - 1) / `SFMIO_CLK_NS,
    parameter int unsigned FIFO_DEPTH = `SFMIO_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic [3:0] serialLineIn,
    output logic [3:0] serialLineOut,
    output logic [3:0] serialLineOe,
    input wire logic quadEnableBit,
    input wire logic fourByteModeFlag,
    input wire logic singleLineMode,
    input wire logic [7:0] extAddr,
    input wire logic writeEnableSet,
    input wire logic pageLocked,
    output logic arrayRdReq,
    output logic [31:0] arrayRdAddr,
    input wire logic [7:0] arrayRdData,
    output logic pgmValid,
    output logic [7:0] pgmOffset,
    output logic [7:0] pgmData,
    input wire logic pgmReady,
    output logic pgmCommit,
    output logic pgmAbort,
    output logic [23:0] pgmPage,
    output logic busyFlag,
    output logic writeEnableLatch
);
    import sfmio_pkg::*;

    sfmio_st_t r;
    sfmio_st_t n;
    sfmio_dec_t opDec;
    logic rise;
    logic fall;
    logic csRise;
    logic opDone;
    logic opAccept;
    logic progDone;
    logic fifoInReady;
    logic fifoEmpty;
    logic [15:0] fifoOut;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode decode: lanes, dummy clocks, address width and gating flags
    function automatic sfmio_dec_t decode(input logic [7:0] op, input logic fbm);
        sfmio_dec_t d;
        d = '0;
        d.ok = 1'h1;
        case (op)
            `SFMIO_OP_READ, `SFMIO_OP_READ4: begin
                d.dummy = 4'h0;
            end
            `SFMIO_OP_FAST, `SFMIO_OP_FAST4: begin
                d.dummy = `SFMIO_DUMMY_FAST;
            end
            `SFMIO_OP_DOUT, `SFMIO_OP_DOUT4: begin
                d.dLog = 2'h1;
                d.dummy = `SFMIO_DUMMY_FAST;
            end
            `SFMIO_OP_QOUT, `SFMIO_OP_QOUT4: begin
                d.dLog = 2'h2;
                d.qe = 1'h1;
                d.dummy = `SFMIO_DUMMY_FAST;
            end
            `SFMIO_OP_DIO, `SFMIO_OP_DIO4: begin
                d.aLog = 2'h1;
                d.dLog = 2'h1;
                d.mode = 1'h1;
                d.dummy = `SFMIO_DUMMY_IO;
            end
            `SFMIO_OP_QIO, `SFMIO_OP_QIO4: begin
                d.aLog = 2'h2;
                d.dLog = 2'h2;
                d.mode = 1'h1;
                d.qe = 1'h1;
                d.dummy = `SFMIO_DUMMY_IO;
            end
            `SFMIO_OP_PROG, `SFMIO_OP_PROG4: begin
                d.pgm = 1'h1;
            end
            default: begin
                d.ok = 1'h0;
            end
        endcase
        d.four = (op == `SFMIO_OP_READ4) || (op == `SFMIO_OP_FAST4)
            || (op == `SFMIO_OP_DOUT4) || (op == `SFMIO_OP_QOUT4)
            || (op == `SFMIO_OP_DIO4) || (op == `SFMIO_OP_QIO4);
        d.a32 = fbm || d.four || (op == `SFMIO_OP_PROG4);
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin edges from the second and third synchroniser stages
    assign rise = r.sclkS2 && !r.sclkS3;
    assign fall = !r.sclkS2 && r.sclkS3;
    assign csRise = r.csS2 && !r.csS3;
    assign opDone = rise && !r.csS2 && (r.phase == SFMIO_IDLE) && (r.cnt == `SFMIO_OPC_LAST);
    assign opDec = decode({r.cmd[6:0], r.ioS2[0]}, fourByteModeFlag);
    // Gating of a freshly received opcode
    assign opAccept = opDec.ok
        && !(opDec.qe && !quadEnableBit)
        && !(opDec.four && !singleLineMode)
        && !r.busy
        && !(opDec.pgm && !r.write_enable_latch);
    assign progDone = r.busy && !r.commitPend && (r.timer == 32'h0000_0001);

    // Outputs all come from state flops
    assign serialLineOut = r.ioOut;
    assign serialLineOe = r.ioOe;
    assign arrayRdReq = r.rdReq;
    assign arrayRdAddr = r.rdAddr;
    assign pgmCommit = r.commit;
    assign pgmAbort = r.abort;
    assign pgmPage = r.page;
    assign busyFlag = r.busy;
    assign writeEnableLatch = r.write_enable_latch;
    assign pgmOffset = fifoOut[15:8];
    assign pgmData = fifoOut[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Program bytes pass through the buffer; a full buffer stalls the push
    sfmio_fifo #(
        .WIDTH(`SFMIO_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(r.pushValid),
        .inData(r.pushData),
        .inReady(fifoInReady),
        .outValid(pgmValid),
        .outData(fifoOut),
        .outReady(pgmReady),
        .isEmpty(fifoEmpty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the whole sequencer
    always_comb begin
        logic [31:0] sh;
        logic [31:0] full;
        logic [7:0] b;
        n = r;
        case (r.dec.aLog)
            2'h1: sh = {r.addr[29:0], r.ioS2[1:0]};
            2'h2: sh = {r.addr[27:0], r.ioS2};
            default: sh = {r.addr[30:0], r.ioS2[0]};
        endcase
        full = r.dec.a32 ? sh : {extAddr, sh[23:0]};
        b = (r.outCnt == 3'h0) ? r.fetch : r.shift;
        n.csS1 = chipSelectN;
        n.csS2 = r.csS1;
        n.csS3 = r.csS2;
        n.sclkS1 = serialClock;
        n.sclkS2 = r.sclkS1;
        n.sclkS3 = r.sclkS2;
        n.ioS1 = serialLineIn;
        n.ioS2 = r.ioS1;
        n.rdReq = 1'h0;
        n.commit = 1'h0;
        n.abort = 1'h0;
        n.rdPend = r.rdReq;
        // Array answers one cycle after the request
        if (r.rdPend) begin
            n.fetch = arrayRdData;
        end
        if (r.pushValid && fifoInReady) begin
            n.pushValid = 1'h0;
        end
        // Timed cycle starts only once every buffered byte has drained
        if (r.commitPend && fifoEmpty && !r.pushValid) begin
            n.commitPend = 1'h0;
            n.commit = 1'h1;
            n.timer = 32'(TPP_CYCLES);
        end else if (r.busy && !r.commitPend) begin
            n.timer = r.timer - 32'h0000_0001;
            if (progDone) begin
                n.busy = 1'h0;
                n.write_enable_latch = 1'h0;
            end
        end
        // A write enable arriving with the cycle end still wins
        if (writeEnableSet) begin
            n.write_enable_latch = 1'h1;
        end
        if (r.csS2) begin
            // Deselected: clear phase, counters, command and line enables; settle any program in flight
            n.phase = SFMIO_IDLE;
            n.cnt = '0;
            n.cmd = '0;
            n.outCnt = '0;
            n.ioOe = '0;
            if (csRise) begin
                if ((r.phase == SFMIO_PDATA) && (r.cnt == 6'h0) && (r.byteCnt != 9'h0)
                    && !r.dropped && !pageLocked) begin
                    n.commitPend = 1'h1;
                    n.busy = 1'h1;
                end else if (r.dec.pgm
                    && ((r.phase == SFMIO_ADDR) || (r.phase == SFMIO_PDATA))) begin
                    n.abort = 1'h1;
                end
            end
        end else if (rise) begin
            n.cnt = r.cnt + 6'h1;
            case (r.phase)
                SFMIO_IDLE: begin
                    n.cmd = {r.cmd[6:0], r.ioS2[0]};
                    if (opDone) begin
                        n.dec = opDec;
                        n.cnt = '0;
                        n.addr = '0;
                        n.aLast = ((opDec.a32 ? `SFMIO_ADDR4_BITS : `SFMIO_ADDR3_BITS)
                            >> opDec.aLog) - 6'h1;
                        n.phase = opAccept ? SFMIO_ADDR : SFMIO_SKIP;
                    end
                end
                SFMIO_ADDR: begin
                    n.addr = sh;
                    if (r.cnt == r.aLast) begin
                        n.cnt = '0;
                        if (r.dec.pgm) begin
                            n.phase = SFMIO_PDATA;
                            n.page = full[31:8];
                            n.offset = full[7:0];
                            n.byteCnt = '0;
                            n.dropped = 1'h0;
                        end else begin
                            n.rdAddr = full;
                            n.rdReq = 1'h1;
                            if (r.dec.mode) begin
                                n.phase = SFMIO_MODE;
                            end else if (r.dec.dummy != 4'h0) begin
                                n.phase = SFMIO_DUMMY;
                            end else begin
                                n.phase = SFMIO_DATA;
                            end
                        end
                    end
                end
                SFMIO_MODE: begin
                    // Mode bits are not interpreted; no continuous read
                    if (r.cnt == 6'(`SFMIO_MODE_BITS >> r.dec.aLog) - 6'h1) begin
                        n.cnt = '0;
                        n.phase = SFMIO_DUMMY;
                    end
                end
                SFMIO_DUMMY: begin
                    // Line values during dummy clocks are ignored
                    if (r.cnt == 6'(r.dec.dummy) - 6'h1) begin
                        n.cnt = '0;
                        n.phase = SFMIO_DATA;
                    end
                end
                SFMIO_PDATA: begin
                    n.shift = {r.shift[6:0], r.ioS2[0]};
                    if (r.cnt == 6'h7) begin
                        n.cnt = '0;
                        n.offset = r.offset + 8'h01;
                        if (r.byteCnt != `SFMIO_BYTES_MAX) begin
                            n.byteCnt = r.byteCnt + 9'h001;
                        end
                        // A byte arriving while the last still waits is lost
                        if (r.pushValid && !fifoInReady) begin
                            n.dropped = 1'h1;
                        end else begin
                            n.pushValid = 1'h1;
                            n.pushData = {r.offset, r.shift[6:0], r.ioS2[0]};
                        end
                    end
                end
                default: begin
                    n.cnt = r.cnt;
                end
            endcase
        end else if (fall && (r.phase == SFMIO_DATA)) begin
            // Lines turn to outputs only at the first data fall
            case (r.dec.dLog)
                2'h1: begin
                    n.ioOut = {2'h0, b[7:6]};
                    n.ioOe = 4'h3;
                    n.shift = {b[5:0], 2'h0};
                end
                2'h2: begin
                    n.ioOut = b[7:4];
                    n.ioOe = 4'hF;
                    n.shift = {b[3:0], 4'h0};
                end
                default: begin
                    n.ioOut = {2'h0, b[7], 1'h0};
                    n.ioOe = 4'h2;
                    n.shift = {b[6:0], 1'h0};
                end
            endcase
            if (r.outCnt == 3'h0) begin
                n.outCnt = 3'h7 >> r.dec.dLog;
                n.rdAddr = r.rdAddr + 32'h0000_0001;
                n.rdReq = 1'h1;
            end else begin
                n.outCnt = r.outCnt - 3'h1;
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    quad_gate_a: assert property (
        (opDone && opDec.qe && !quadEnableBit) |=> (r.phase == SFMIO_SKIP))
        else $error("quad read accepted without quad enable");
    four_gate_a: assert property (
        (opDone && opDec.four && !singleLineMode) |=> (r.phase == SFMIO_SKIP))
        else $error("four-byte read accepted outside single-line mode");
    wel_gate_a: assert property (
        (opDone && opDec.pgm && !r.write_enable_latch) |=> (r.phase == SFMIO_SKIP))
        else $error("program accepted without write enable");
    busy_ignore_a: assert property (
        (opDone && r.busy && !progDone) |=> (r.phase == SFMIO_SKIP) && busyFlag)
        else $error("instruction accepted while busy");
    addr_width_a: assert property (
        (opDone && opAccept) |=> (r.dec.a32 == ($past(fourByteModeFlag) || r.dec.four
            || (r.cmd == `SFMIO_OP_PROG4))))
        else $error("wrong address width chosen");
    addr_len_a: assert property (
        ($past(r.phase) == SFMIO_ADDR) && (r.phase != SFMIO_ADDR) && !r.csS2
        |-> ($past(r.cnt) == ((r.dec.a32 ? 6'h20 : 6'h18) >> r.dec.aLog) - 6'h1))
        else $error("address phase length wrong");
    dummy_len_a: assert property (
        ($past(r.phase) == SFMIO_DUMMY) && (r.phase == SFMIO_DATA)
        |-> ($past(r.cnt) == (r.dec.mode ? 6'h3 : 6'h7)))
        else $error("dummy phase length wrong");
    ext_addr_a: assert property (
        (arrayRdReq && ($past(r.phase) == SFMIO_ADDR) && !r.dec.a32)
        |-> (arrayRdAddr[31:24] == $past(extAddr)))
        else $error("extended address byte not used");
    dual_out_a: assert property (
        (fall && (r.phase == SFMIO_DATA) && (r.outCnt == 3'h0) && (r.dec.dLog == 2'h1))
        |=> (serialLineOe == 4'h3) && (serialLineOut[1:0] == $past(r.fetch[7:6])))
        else $error("dual data lanes wrong");
    quad_out_a: assert property (
        (fall && (r.phase == SFMIO_DATA) && (r.outCnt == 3'h0) && (r.dec.dLog == 2'h2))
        |=> (serialLineOe == 4'hF) && (serialLineOut == $past(r.fetch[7:4])))
        else $error("quad data lanes wrong");
    addr_step_a: assert property (
        (arrayRdReq && ($past(r.phase) == SFMIO_DATA))
        |-> (arrayRdAddr == $past(arrayRdAddr) + 32'h0000_0001))
        else $error("read address did not step by one");
    page_wrap_a: assert property (
        (rise && !r.csS2 && (r.phase == SFMIO_PDATA) && (r.cnt == 6'h7))
        |=> (r.offset == $past(r.offset) + 8'h01) && (r.page == $past(r.page)))
        else $error("page offset did not wrap in page");
    bad_end_a: assert property (
        (csRise && (r.phase == SFMIO_PDATA) && ((r.cnt != 6'h0) || pageLocked))
        |=> pgmAbort && !r.commitPend)
        else $error("bad program end not discarded");
    prog_busy_a: assert property (
        (csRise && (r.phase == SFMIO_PDATA) && (r.cnt == 6'h0) && (r.byteCnt != 9'h0)
            && !r.dropped && !pageLocked) |=> busyFlag [*2])
        else $error("busy not raised for program cycle");
    prog_end_a: assert property (
        (progDone && !writeEnableSet) |=> !busyFlag && !writeEnableLatch)
        else $error("cycle end left busy or write enable");
    byte_count_a: assert property (
        pgmCommit |-> (r.byteCnt != 9'h0) && (r.byteCnt <= `SFMIO_BYTES_MAX))
        else $error("program byte count out of range");

endmodule // sfmio_core
`default_nettype wire

// File: sfmio_defines.svh
// Opcodes, phase lengths and timing constants of the multi-IO flash sequencer
`ifndef SFMIO_DEFINES_SVH
`define SFMIO_DEFINES_SVH

// Read and program opcodes
`define SFMIO_OP_READ 8'h03
`define SFMIO_OP_READ4 8'h13
`define SFMIO_OP_FAST 8'h0B
`define SFMIO_OP_FAST4 8'h0C
`define SFMIO_OP_DOUT 8'h3B
`define SFMIO_OP_DOUT4 8'h3C
`define SFMIO_OP_QOUT 8'h6B
`define SFMIO_OP_QOUT4 8'h6C
`define SFMIO_OP_DIO 8'hBB
`define SFMIO_OP_DIO4 8'hBC
`define SFMIO_OP_QIO 8'hEB
`define SFMIO_OP_QIO4 8'hEC
`define SFMIO_OP_PROG 8'h02
`define SFMIO_OP_PROG4 8'h12

// Phase lengths in serial clocks or bits
`define SFMIO_OPC_LAST 6'h07
`define SFMIO_DUMMY_FAST 4'h8
`define SFMIO_DUMMY_IO 4'h4
`define SFMIO_ADDR3_BITS 6'h18
`define SFMIO_ADDR4_BITS 6'h20
`define SFMIO_MODE_BITS 4'h8
`define SFMIO_BYTES_MAX 9'h100

// Timing: system clock period and program cycle length in ns
`define SFMIO_CLK_NS 8
`define SFMIO_TPP_NS 400000

// Program byte buffer shape: offset byte plus data byte
`define SFMIO_FIFO_WIDTH 16
`define SFMIO_FIFO_DEPTH 8

`endif

// File: sfmio_fifo.sv
// Program byte buffer with registered output stage
`timescale 1ns/100ps
`default_nettype none
`include "sfmio_defines.svh"

module sfmio_fifo #(
    parameter int unsigned WIDTH = `SFMIO_FIFO_WIDTH,
    parameter int unsigned DEPTH = `SFMIO_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    output logic isEmpty
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } sfmio_fifo_st_t;

    sfmio_fifo_st_t r;
    sfmio_fifo_st_t n;
    logic wr;
    logic rd;

    // Storage count excludes the output register; full stalls the writer
    assign inReady = (r.cnt != (AW + 1)'(DEPTH));
    assign outValid = r.ov;
    assign outData = r.od;
    assign isEmpty = (r.cnt == '0) && !r.ov;
    assign wr = inValid && inReady;
    assign rd = (r.cnt != '0) && (!r.ov || outReady);

    // Next state: write, then refill the output register when it frees up
    always_comb begin
        n = r;
        if (wr) begin
            n.mem[r.wp] = inData;
            n.wp = r.wp + AW'(1);
        end
        if (rd) begin
            n.od = r.mem[r.rp];
            n.rp = r.rp + AW'(1);
            n.ov = 1'h1;
        end else if (outReady) begin
            n.ov = 1'h0;
        end
        n.cnt = r.cnt + (AW + 1)'(wr) - (AW + 1)'(rd);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule // sfmio_fifo
`default_nettype wire

// File: sfmio_host_model.sv
// SPI host model that frames transfers on the flash pins
`timescale 1ns/100ps
`default_nettype none
module sfmio_host_model (
    output logic chipSelectN,
    output logic serialClock,
    output logic [3:0] serialLineIn,
    input wire logic [3:0] serialLineOut
);
    logic [7:0] b;
    // Deselected, with the clock parked low between frames
    initial begin
        chipSelectN = 1'h1;
        serialClock = 1'h0;
        serialLineIn = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Select edge with a long guard so the device sees every clock edge
    task automatic sel(input logic v);
        #80 chipSelectN = v;
    endtask
    // n clocks of w bits each, most significant group first
    task automatic tx(input logic [31:0] v, input int n, input int w);
        for (int i = n - 1; i >= 0; i--) begin
            serialLineIn = 4'((v >> (i * w)) & ((1 << w) - 1));
            #40 serialClock = 1'h1;
            #40 serialClock = 1'h0;
        end
    endtask
    // One byte in; released lines toggle so a stale level never looks valid
    task automatic rx(input int w);
        for (int i = 0; i < 8 / w; i++) begin
            serialLineIn = ~serialLineIn;
            #40 serialClock = 1'h1;
            b = (b << w) | 8'((w == 1) ? 4'(serialLineOut[1]) : serialLineOut & 4'((1 << w) - 1));
            #40 serialClock = 1'h0;
        end
    endtask
endmodule // sfmio_host_model
`default_nettype wire

// File: sfmio_pkg.sv
// Types shared by the multi-IO flash sequencer
package sfmio_pkg;

    typedef enum logic [2:0] {
        SFMIO_IDLE  = 3'b000,
        SFMIO_ADDR  = 3'b001,
        SFMIO_MODE  = 3'b010,
        SFMIO_DUMMY = 3'b011,
        SFMIO_DATA  = 3'b100,
        SFMIO_PDATA = 3'b101,
        SFMIO_SKIP  = 3'b110
    } sfmio_phase_t;

    // Decoded opcode properties
    typedef struct packed {
        logic ok;
        logic a32;
        logic four;
        logic qe;
        logic pgm;
        logic mode;
        logic [1:0] aLog;
        logic [1:0] dLog;
        logic [3:0] dummy;
    } sfmio_dec_t;

    // Whole state of the sequencer
    typedef struct packed {
        logic csS1;
        logic csS2;
        logic csS3;
        logic sclkS1;
        logic sclkS2;
        logic sclkS3;
        logic [3:0] ioS1;
        logic [3:0] ioS2;
        sfmio_phase_t phase;
        logic [7:0] cmd;
        sfmio_dec_t dec;
        logic [31:0] addr;
        logic [5:0] cnt;
        logic [5:0] aLast;
        logic [7:0] shift;
        logic [2:0] outCnt;
        logic [7:0] fetch;
        logic rdPend;
        logic rdReq;
        logic [31:0] rdAddr;
        logic [3:0] ioOut;
        logic [3:0] ioOe;
        logic [8:0] byteCnt;
        logic [7:0] offset;
        logic pushValid;
        logic [15:0] pushData;
        logic dropped;
        logic [23:0] page;
        logic commitPend;
        logic commit;
        logic abort;
        logic busy;
        logic write_enable_latch;
        logic [31:0] timer;
    } sfmio_st_t;

endpackage

// File: test_serial_flash_multi_io_read_program.sv
// Self-checking bench for the multi-IO flash read and program sequencer
`timescale 1ns/100ps
`default_nettype none
module test_serial_flash_multi_io_read_program;
    logic clk = 1'h0, resetn = 1'h0, quadEnableBit = 1'h1, singleLineMode = 1'h1;
    logic writeEnableSet = 1'h0, pageLocked = 1'h0, pgmReady = 1'h0, oeAny;
    logic chipSelectN, serialClock, arrayRdReq, pgmValid, pgmCommit, pgmAbort;
    logic busyFlag, writeEnableLatch;
    logic [3:0] serialLineIn, serialLineOut, serialLineOe;
    logic [7:0] arrayRdData = 8'h00, pgmOffset, pgmData;
    logic [23:0] pgmPage;
    logic [31:0] arrayRdAddr;
    logic [15:0] words[$];
    int failCount = 0, checked = 0, commits, n;
    localparam logic [7:0] EXT = 8'hA5;
    logic fourByteModeFlag = 1'h0;
    logic [7:0] extAddr = EXT;
    sfmio_host_model h (.chipSelectN, .serialClock, .serialLineIn, .serialLineOut);
    sfmio_core #(.TPP_CYCLES(1000)) dut (.clk, .resetn, .chipSelectN, .serialClock,
        .serialLineIn, .serialLineOut, .serialLineOe, .quadEnableBit,
        .fourByteModeFlag, .singleLineMode, .extAddr, .writeEnableSet,
        .pageLocked, .arrayRdReq, .arrayRdAddr, .arrayRdData, .pgmValid, .pgmOffset,
        .pgmData, .pgmReady, .pgmCommit, .pgmAbort, .pgmPage, .busyFlag,
        .writeEnableLatch);
    ////////////////////////////////////////////////////////////////////////////////
    // Array content mixes address bytes 0, 1 and 3 so a wrong upper byte shows
    function automatic logic [7:0] fa(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ a[31:24];
    endfunction
    initial forever #4 clk = ~clk;
    // Array answers a cycle after its request; program traffic is logged
    always @(posedge clk) begin
        if (arrayRdReq) arrayRdData <= fa(arrayRdAddr);
        if (pgmValid && pgmReady) words.push_back({pgmOffset, pgmData});
        if (pgmCommit) commits++;
        if (|serialLineOe) oeAny = 1'h1;
    end
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // Read two bytes across a page step; a refused frame drives no line
    task automatic rdf(input logic [7:0] op, input int aw, mc, dc, ow, ab, input logic ok);
        logic [31:0] a;
        logic [7:0] b0;
        a = (ab == 32) ? 32'h3C00_12FF : {EXT, 24'h00_12FF};
        // Host edges land on falling clk edges; lines of the last frame settle first
        repeat (4) @(negedge clk);
        oeAny = 1'h0;
        h.sel(1'h0);
        h.tx(32'(op), 8, 1);
        h.tx(a, ab / aw, aw);
        h.tx(32'hFFFF_FFFF, mc, aw);
        h.tx(32'h0000_0000, dc, 1);
        h.rx(ow);
        b0 = h.b;
        h.rx(ow);
        h.sel(1'h1);
        if (ok) begin
            chk("first byte", 32'(b0), 32'(fa(a)));
            chk("second byte", 32'(h.b), 32'(fa(a + 1)));
        end else begin
            chk("lines driven", 32'(oeAny), 32'h0000_0000);
        end
    endtask
    // Program at offset FE; the consumer stalls until select rises
    task automatic pgm(input int nb, cut, input logic we, ok);
        words.delete();
        commits = 0;
        @(posedge clk) writeEnableSet <= we;
        pgmReady <= 1'h0;
        @(posedge clk) writeEnableSet <= 1'h0;
        @(negedge clk);
        h.sel(1'h0);
        h.tx(32'h0000_0002, 8, 1);
        h.tx(32'h0000_34FE, 24, 1);
        for (int i = 1; i <= nb; i++) h.tx(32'h0000_0011 * i, 8, 1);
        h.tx(32'h0000_0000, cut, 1);
        h.sel(1'h1);
        @(posedge clk) pgmReady <= 1'h1;
        for (n = 0; n < 40 && busyFlag !== 1'h1; n++) @(negedge clk);
        chk("busy", 32'(busyFlag), 32'(ok));
        if (ok) begin
            rdf(8'h03, 1, 0, 0, 1, 24, 1'h0);
            for (n = 0; n < 1200 && busyFlag !== 1'h0; n++) @(negedge clk);
            chk("idle", 32'(busyFlag), 32'h0000_0000);
            chk("latch", 32'(writeEnableLatch), 32'h0000_0000);
            chk("page", 32'(pgmPage), {8'h00, EXT, 16'h0034});
            chk("count", words.size(), 32'h0000_0003);
            foreach (words[i]) begin
                chk("word", 32'(words[i]), {8'hFE + 8'(i), 8'h11 * 8'(i + 1)});
            end
        end
        chk("commits", commits, 32'(ok));
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        #400000 failCount++;
        finish_test();
    end
    // Reset, every read form, refusals, then programs
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        repeat (4) @(posedge clk);
        rdf(8'h03, 1, 0, 0, 1, 24, 1'h1);
        rdf(8'h0B, 1, 0, 8, 1, 24, 1'h1);
        rdf(8'h3B, 1, 0, 8, 2, 24, 1'h1);
        rdf(8'h6B, 1, 0, 8, 4, 24, 1'h1);
        rdf(8'hBB, 2, 4, 4, 2, 24, 1'h1);
        rdf(8'hEB, 4, 2, 4, 4, 24, 1'h1);
        rdf(8'h0C, 1, 0, 8, 1, 32, 1'h1);
        rdf(8'h13, 1, 0, 0, 1, 32, 1'h1);
        rdf(8'h3C, 1, 0, 8, 2, 32, 1'h1);
        rdf(8'h6C, 1, 0, 8, 4, 32, 1'h1);
        rdf(8'hBC, 2, 4, 4, 2, 32, 1'h1);
        rdf(8'hEC, 4, 2, 4, 4, 32, 1'h1);
        @(posedge clk) fourByteModeFlag <= 1'h1;
        rdf(8'h03, 1, 0, 0, 1, 32, 1'h1);
        rdf(8'h3B, 1, 0, 8, 2, 32, 1'h1);
        @(posedge clk) fourByteModeFlag <= 1'h0;
        quadEnableBit <= 1'h0;
        rdf(8'h6B, 1, 0, 8, 4, 24, 1'h0);
        rdf(8'hEB, 4, 2, 4, 4, 24, 1'h0);
        @(posedge clk) singleLineMode <= 1'h0;
        quadEnableBit <= 1'h1;
        rdf(8'h0C, 1, 0, 8, 1, 32, 1'h0);
        @(posedge clk) singleLineMode <= 1'h1;
        pgm(3, 0, 1'h1, 1'h1);
        pgm(1, 0, 1'h0, 1'h0);
        pgm(1, 3, 1'h1, 1'h0);
        @(posedge clk) pageLocked <= 1'h1;
        pgm(1, 0, 1'h1, 1'h0);
        finish_test();
    end
endmodule // test_serial_flash_multi_io_read_program
`default_nettype wire
